// ===== rtl/bbm_mode_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module bbm_mode_ctrl
    import bbm_pkg::*;
#(
    parameter int TLAG_LONG_CYC = BBM_TLAG_LONG_CYC,
    parameter int TLAG_SHORT_CYC = BBM_TLAG_SHORT_CYC,
    parameter int FSW_DIV = BBM_FSW_DIV
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_mode,
    input wire logic auto_upshift_enable,
    input wire logic pin_modulation_select,
    input wire logic settle_delay_select,
    input wire logic step_up_enable,
    input wire logic upshift_flag_clear,
    input wire logic step_up_flag_clear,
    input wire logic wake_input_pin,
    input wire logic transceiver_wake,
    input wire logic load_over_threshold,
    input wire logic supply_below_threshold,
    input wire logic supply_above_hysteresis,
    input wire logic step_down_above_reset,
    input wire logic step_down_at_target,
    input wire logic step_up_overcurrent,
    input wire logic [BBM_FAULT_W-1:0] fault_inputs,
    output logic [2:0] chip_mode,
    output logic step_down_on,
    output logic step_down_pwm,
    output logic step_down_clk_tick,
    output logic [BBM_DUTY_W-1:0] step_down_duty,
    output logic step_up_on,
    output logic step_up_pwm,
    output logic [BBM_DUTY_W-1:0] step_up_duty,
    output logic step_up_active_flag,
    output logic auto_upshift_flag,
    output logic [7:0] wake_status_one,
    output logic upshift_event,
    output logic reset_output_pin_low_n,
    output logic [BBM_FAULT_W-1:0] converter_fault_status
);
    bbm_mode_e mode_ff;
    logic [2:0] wk_sync_ff;
    logic wk_level_ff;
    logic [2:0] load_sync_ff;
    logic load_level_ff;
    logic [BBM_CNT_W-1:0] lag_cnt_ff;
    logic armed_ff;
    logic auto_pwm_ff;
    logic flag_ff;
    logic event_ff;
    logic [7:0] div_ff;
    logic tick_ff;
    logic boost_run_ff;
    logic boost_act_ff;
    logic ro_ff;
    logic [BBM_FAULT_W-1:0] fault_ff;
    logic stop_cmd;
    logic in_stop;
    logic pwm_req;
    logic pin_pwm;
    logic wake_evt;
    logic sd_enable;
    logic su_enable;

    function automatic logic [BBM_CNT_W-1:0] lag_count(input logic sel);
        lag_count = sel ? BBM_CNT_W'(TLAG_LONG_CYC - 1)
                        : BBM_CNT_W'(TLAG_SHORT_CYC - 1);
    endfunction

    assign stop_cmd = cmd_valid && (cmd_mode == 3'(BBM_MODE_STOP));
    assign in_stop = (mode_ff == BBM_MODE_STOP);
    // wake pin level taken from the sync after its two-sample agreement filter
    assign pin_pwm = pin_modulation_select && wk_level_ff;
    assign wake_evt = wk_level_ff || transceiver_wake;

    // mode sequencing; fault status takes no part here
    always_ff @(posedge clk) begin
        if (reset) begin
            mode_ff <= BBM_MODE_RESTART;
        end else begin
            case (mode_ff)
                BBM_MODE_SLEEP, BBM_MODE_FAILSAFE: begin
                    if (wake_evt) begin
                        mode_ff <= BBM_MODE_RESTART;
                    end
                end
                BBM_MODE_RESTART: begin
                    if (ro_ff) begin
                        mode_ff <= BBM_MODE_NORMAL;
                    end
                end
                default: begin
                    if (cmd_valid) begin
                        case (cmd_mode)
                            3'(BBM_MODE_NORMAL): mode_ff <= BBM_MODE_NORMAL;
                            3'(BBM_MODE_STOP): mode_ff <= BBM_MODE_STOP;
                            3'(BBM_MODE_SLEEP): mode_ff <= BBM_MODE_SLEEP;
                            3'(BBM_MODE_FAILSAFE): begin
                                mode_ff <= BBM_MODE_FAILSAFE;
                            end
                            default: mode_ff <= mode_ff;
                        endcase
                    end
                end
            endcase
        end
    end

    // three-stage syncs; second and third must agree before a change counts
    always_ff @(posedge clk) begin
        if (reset) begin
            wk_sync_ff <= 3'h0;
            wk_level_ff <= 1'b0;
            load_sync_ff <= 3'h0;
            load_level_ff <= 1'b0;
        end else begin
            wk_sync_ff <= {wk_sync_ff[1:0], wake_input_pin};
            load_sync_ff <= {load_sync_ff[1:0], load_over_threshold};
            if (wk_sync_ff[1] == wk_sync_ff[2]) begin
                wk_level_ff <= wk_sync_ff[2];
            end
            if (load_sync_ff[1] == load_sync_ff[2]) begin
                load_level_ff <= load_sync_ff[2];
            end
        end
    end

    // settle delay restarts on every stop command, so each stop-commanded pwm to pfm
    // hand-over waits it out, including the one after an upshift
    always_ff @(posedge clk) begin
        if (reset || !in_stop) begin
            lag_cnt_ff <= lag_count(settle_delay_select);
            armed_ff <= 1'b0;
        end else if (stop_cmd) begin
            lag_cnt_ff <= lag_count(settle_delay_select);
            armed_ff <= 1'b0;
        end else if (!armed_ff) begin
            if (lag_cnt_ff == '0) begin
                armed_ff <= 1'b1;
            end else begin
                lag_cnt_ff <= lag_cnt_ff - 1'b1;
            end
        end
    end

    // automatic upshift latch
    always_ff @(posedge clk) begin
        if (reset || !in_stop) begin
            auto_pwm_ff <= 1'b0;
            event_ff <= 1'b0;
        end else begin
            event_ff <= 1'b0;
            if (stop_cmd) begin
                auto_pwm_ff <= 1'b0;
            end else if (armed_ff && auto_upshift_enable && load_level_ff
                         && !auto_pwm_ff) begin
                auto_pwm_ff <= 1'b1;
                event_ff <= 1'b1;
            end
        end
    end

    // sticky flag: a new upshift beats a clear in the same cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            flag_ff <= 1'b0;
        end else if (event_ff) begin
            flag_ff <= 1'b1;
        end else if (upshift_flag_clear) begin
            flag_ff <= 1'b0;
        end
    end

    // pfm in stop unless upshift or pin asks pwm; pwm until settle elapsed
    always_comb begin
        pwm_req = 1'b1;
        if (in_stop) begin
            pwm_req = !armed_ff || auto_pwm_ff || pin_pwm;
        end
    end

    assign sd_enable = (mode_ff == BBM_MODE_NORMAL) || in_stop
                       || (mode_ff == BBM_MODE_RESTART);

    // fixed-frequency switching tick
    always_ff @(posedge clk) begin
        if (reset || !sd_enable) begin
            div_ff <= 8'h00;
            tick_ff <= 1'b0;
        end else if (div_ff == 8'(FSW_DIV - 1)) begin
            div_ff <= 8'h00;
            tick_ff <= 1'b1;
        end else begin
            div_ff <= div_ff + 8'h01;
            tick_ff <= 1'b0;
        end
    end

    // step-up: hysteretic on/off, held across stop and normal unchanged
    always_ff @(posedge clk) begin
        if (reset || !step_up_enable || !sd_enable) begin
            boost_run_ff <= 1'b0;
        end else if (supply_below_threshold) begin
            boost_run_ff <= 1'b1;
        end else if (supply_above_hysteresis) begin
            boost_run_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            boost_act_ff <= 1'b0;
        end else if (boost_run_ff) begin
            boost_act_ff <= 1'b1;
        end else if (step_up_flag_clear && !supply_below_threshold) begin
            boost_act_ff <= 1'b0;
        end
    end

    // reset output held low until restart sees the output up
    always_ff @(posedge clk) begin
        if (reset || (mode_ff == BBM_MODE_SLEEP)
            || (mode_ff == BBM_MODE_FAILSAFE)) begin
            ro_ff <= 1'b0;
        end else if (step_down_above_reset) begin
            ro_ff <= 1'b1;
        end
    end

    // fault bits are reported only
    always_ff @(posedge clk) begin
        if (reset) begin
            fault_ff <= '0;
        end else begin
            fault_ff <= fault_inputs & (BBM_FAULT_OPEN | BBM_FAULT_SHORT
                                        | BBM_FAULT_GND);
        end
    end

    // gated by mode so the stage drops in the same cycle as the step-down
    assign su_enable = boost_run_ff && sd_enable;

    bbm_softstart #(
        .PERIODS(BBM_SS_PERIODS)
    ) u_sd_ramp (
        .clk(clk),
        .reset(reset),
        .enable(sd_enable),
        .period_tick(tick_ff),
        .target_reached(step_down_at_target),
        .overcurrent(1'b0),
        .duty(step_down_duty),
        .ramp_done()
    );

    bbm_softstart #(
        .PERIODS(BBM_SS_PERIODS)
    ) u_su_loop (
        .clk(clk),
        .reset(reset),
        .enable(su_enable),
        .period_tick(tick_ff),
        .target_reached(1'b0),
        .overcurrent(step_up_overcurrent),
        .duty(step_up_duty),
        .ramp_done()
    );

    assign chip_mode = 3'(mode_ff);
    assign step_down_on = sd_enable;
    assign step_down_pwm = sd_enable && pwm_req;
    assign step_down_clk_tick = tick_ff;
    assign step_up_on = su_enable;
    assign step_up_pwm = su_enable;
    assign step_up_active_flag = boost_act_ff;
    assign auto_upshift_flag = flag_ff;
    assign wake_status_one = {7'h00, flag_ff};
    assign upshift_event = event_ff;
    assign reset_output_pin_low_n = ro_ff;
    assign converter_fault_status = fault_ff;
endmodule
`default_nettype wire

// ===== rtl/bbm_pkg.sv
package bbm_pkg;
    localparam int BBM_CLK_HZ = 100_000_000;
    // settle delay figures, in microseconds as printed
    localparam int BBM_TLAG_LONG_US = 1000;
    localparam int BBM_TLAG_SHORT_US = 100;
    localparam int BBM_TLAG_LONG_CYC = BBM_TLAG_LONG_US * (BBM_CLK_HZ / 1_000_000);
    localparam int BBM_TLAG_SHORT_CYC =
        BBM_TLAG_SHORT_US * (BBM_CLK_HZ / 1_000_000);
    // nominal step-down switching frequency in kHz
    localparam int BBM_FSW_KHZ = 450;
    localparam int BBM_FSW_DIV = BBM_CLK_HZ / (BBM_FSW_KHZ * 1000);
    localparam int BBM_CNT_W = 20;
    localparam int BBM_DUTY_W = 8;
    localparam logic [7:0] BBM_DUTY_MIN = 8'h08;
    localparam logic [7:0] BBM_DUTY_STEP = 8'h08;
    localparam logic [7:0] BBM_DUTY_MAX = 8'hff;
    localparam int BBM_SS_PERIODS = 4;
    localparam int BBM_FAULT_W = 3;
    localparam logic [2:0] BBM_FAULT_OPEN = 3'h1;
    localparam logic [2:0] BBM_FAULT_SHORT = 3'h2;
    localparam logic [2:0] BBM_FAULT_GND = 3'h4;

    typedef enum logic [2:0] {
        BBM_MODE_NORMAL,
        BBM_MODE_STOP,
        BBM_MODE_SLEEP,
        BBM_MODE_FAILSAFE,
        BBM_MODE_RESTART
    } bbm_mode_e;
endpackage

// ===== rtl/bbm_softstart.sv
`timescale 1ns/1ps
`default_nettype none
// soft-start ramp and peak-current duty limiter for one converter stage
module bbm_softstart
    import bbm_pkg::*;
#(
    parameter int PERIODS = BBM_SS_PERIODS
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic enable,
    input wire logic period_tick,
    input wire logic target_reached,
    input wire logic overcurrent,
    output logic [BBM_DUTY_W-1:0] duty,
    output logic ramp_done
);
    logic [BBM_DUTY_W-1:0] duty_ff;
    logic [7:0] hold_ff;
    logic done_ff;

    always_ff @(posedge clk) begin
        if (reset || !enable) begin
            duty_ff <= BBM_DUTY_MIN;
            hold_ff <= 8'h00;
            done_ff <= 1'b0;
        end else if (period_tick) begin
            if (overcurrent) begin
                // no ramp step while the peak limit trips, else it would
                // climb straight back into the overcurrent
                if (duty_ff >= BBM_DUTY_MIN + BBM_DUTY_STEP) begin
                    duty_ff <= duty_ff - BBM_DUTY_STEP;
                end
            end else if (!done_ff) begin
                if (target_reached) begin
                    done_ff <= 1'b1;
                end else if (hold_ff == 8'(PERIODS - 1)) begin
                    hold_ff <= 8'h00;
                    if (duty_ff <= BBM_DUTY_MAX - BBM_DUTY_STEP) begin
                        duty_ff <= duty_ff + BBM_DUTY_STEP;
                    end
                end else begin
                    hold_ff <= hold_ff + 8'h01;
                end
            end
        end
    end

    assign duty = duty_ff;
    assign ramp_done = done_ff;
endmodule
`default_nettype wire

// ===== bench/bbm_mode_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module bbm_mode_ctrl_sva (
    input wire logic clk,
    input wire logic reset,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_mode,
    input wire logic pin_modulation_select,
    input wire logic wake_input_pin,
    input wire logic transceiver_wake,
    input wire logic step_down_above_reset,
    input wire logic [2:0] chip_mode,
    input wire logic step_down_on,
    input wire logic step_down_pwm,
    input wire logic step_up_on,
    input wire logic step_up_pwm,
    input wire logic auto_upshift_flag,
    input wire logic upshift_flag_clear,
    input wire logic [7:0] wake_status_one,
    input wire logic upshift_event,
    input wire logic reset_output_pin_low_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_low_power_off: assert property (chip_mode inside {3'h2, 3'h3} |->
        !step_down_on && !step_up_on) else $error("stage on in sleep");
    a_normal_runs_pwm: assert property (chip_mode == 3'h0 |->
        step_down_pwm) else $error("normal mode not pwm");
    a_step_up_pwm: assert property (step_up_on |-> step_up_pwm)
        else $error("step-up left pwm");
    a_event_sets_flag: assert property (upshift_event |=>
        auto_upshift_flag && !upshift_event) else $error("event without flag");
    a_flag_sticky: assert property (auto_upshift_flag &&
        !upshift_flag_clear |=> auto_upshift_flag) else $error("flag lost");
    a_event_in_stop: assert property (upshift_event |->
        chip_mode == 3'h1) else $error("upshift outside stop");
    a_status_mirror: assert property (wake_status_one ==
        {7'h0, auto_upshift_flag}) else $error("status mismatch");
    a_normal_holds: assert property (chip_mode == 3'h0 && !cmd_valid |=>
        chip_mode == 3'h0) else $error("mode changed without command");
    a_stop_to_normal: assert property (chip_mode == 3'h1 && cmd_valid &&
        cmd_mode == 3'h0 |=> chip_mode == 3'h0 && step_down_pwm)
        else $error("stop to normal failed");
    a_restart_ro: assert property (chip_mode == 3'h4 &&
        step_down_above_reset |=> reset_output_pin_low_n)
        else $error("reset output held");
    a_restart_on: assert property (chip_mode == 3'h4 |-> step_down_on)
        else $error("step-down off in restart");
    a_wake_restart: assert property (chip_mode == 3'h2 &&
        transceiver_wake |-> ##[1:6] chip_mode == 3'h4)
        else $error("wake ignored");
    a_pin_pwm: assert property ((chip_mode == 3'h1 &&
        pin_modulation_select && wake_input_pin) [*6] |-> step_down_pwm)
        else $error("pin select ignored");
    cover property (upshift_event);
    cover property (chip_mode == 3'h4 ##1 chip_mode == 3'h0);
    cover property (chip_mode == 3'h1 && !step_down_pwm);
endmodule
bind bbm_mode_ctrl bbm_mode_ctrl_sva chk_u (.clk, .reset, .cmd_valid,
    .cmd_mode, .pin_modulation_select, .wake_input_pin, .transceiver_wake,
    .step_down_above_reset, .chip_mode, .step_down_on, .step_down_pwm,
    .step_up_on, .step_up_pwm, .auto_upshift_flag, .upshift_flag_clear,
    .wake_status_one, .upshift_event, .reset_output_pin_low_n);
`default_nettype wire

// ===== bench/bbm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// microcontroller side: issues mode commands one cycle wide
module bbm_host_model (
    input wire logic clk,
    input wire logic load_over_threshold,
    output logic cmd_valid,
    output logic [2:0] cmd_mode
);
    initial begin
        cmd_valid = 1'b0;
        cmd_mode = 3'h0;
    end
    task automatic send(input logic [2:0] m);
        int n;
        n = 0;
        // stop waits up to 100 cycles for the load to drop again before it is sent
        while (m == 3'h1 && load_over_threshold && n < 100) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_mode = m;
        @(negedge clk);
        cmd_valid = 1'b0;
        // idle field shows no stale command
        cmd_mode = ~m;
    endtask
endmodule
`default_nettype wire

// ===== bench/bbm_mode_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module bbm_mode_ctrl_test
    import bbm_pkg::*;
;
    logic clk;
    logic reset;
    logic cmd_valid, step_down_on, step_down_pwm, step_down_clk_tick;
    logic [2:0] cmd_mode, chip_mode;
    logic auto_upshift_enable, pin_modulation_select;
    logic settle_delay_select, step_up_enable;
    logic upshift_flag_clear, step_up_flag_clear;
    logic wake_input_pin, transceiver_wake;
    logic load_over_threshold, supply_below_threshold;
    logic supply_above_hysteresis, step_down_above_reset;
    logic step_down_at_target, step_up_overcurrent;
    logic [2:0] fault_inputs;
    logic [2:0] converter_fault_status;
    logic [7:0] step_down_duty, step_up_duty, wake_status_one, d0, d1;
    logic step_up_on, step_up_pwm, step_up_active_flag, auto_upshift_flag;
    logic upshift_event, reset_output_pin_low_n;
    int bad_count = 0;
    int compares = 0;
    int cyc = 0;
    int seed = 80;
    int n;
    logic [2:0] mode_q[$];
    logic [2:0] last_mode = 3'h4;

    initial clk = 1'b0;
    always #5 clk = ~clk;

    bbm_host_model host_u (.clk, .load_over_threshold, .cmd_valid, .cmd_mode);
    // short settle delays keep the run brief
    bbm_mode_ctrl #(.TLAG_LONG_CYC(20), .TLAG_SHORT_CYC(5)) dut_u (.clk,
        .reset, .cmd_valid, .cmd_mode, .auto_upshift_enable,
        .pin_modulation_select, .settle_delay_select, .step_up_enable,
        .upshift_flag_clear, .step_up_flag_clear, .wake_input_pin,
        .transceiver_wake, .load_over_threshold, .supply_below_threshold,
        .supply_above_hysteresis, .step_down_above_reset, .step_down_at_target,
        .step_up_overcurrent, .fault_inputs, .chip_mode, .step_down_on,
        .step_down_pwm, .step_down_clk_tick, .step_down_duty, .step_up_on,
        .step_up_pwm, .step_up_duty, .step_up_active_flag, .auto_upshift_flag,
        .wake_status_one, .upshift_event, .reset_output_pin_low_n,
        .converter_fault_status);

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic c1(input logic s, input logic e);
        check({7'h0, s}, {7'h0, e});
    endtask
    task automatic wt(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic results();
        if (bad_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // every mode change takes the oldest note; an unannounced one fails
    always @(negedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            bad_count++;
            results();
        end else if (chip_mode !== last_mode) begin
            if (mode_q.size() == 0) check({5'h0, chip_mode}, 8'hff);
            else check({5'h0, chip_mode}, {5'h0, mode_q.pop_front()});
            last_mode = chip_mode;
        end
    end

    initial begin
        reset = 1'b1;
        {auto_upshift_enable, pin_modulation_select} = 2'h0;
        {settle_delay_select, step_up_enable} = 2'h0;
        {upshift_flag_clear, step_up_flag_clear} = 2'h0;
        {wake_input_pin, transceiver_wake} = 2'h0;
        {load_over_threshold, supply_below_threshold} = 2'h0;
        {supply_above_hysteresis, step_down_above_reset} = 2'h0;
        {step_down_at_target, step_up_overcurrent} = 2'h0;
        fault_inputs = 3'h0;
        wt(5);
        reset = 1'b0;
        mode_q.push_back(3'h0);
        step_down_above_reset = 1'b1;
        wt(4);
        c1(reset_output_pin_low_n, 1'b1);
        c1(step_down_pwm, 1'b1);
        for (n = 0; n < 300 && !step_down_clk_tick; n++) @(negedge clk);
        @(negedge clk);
        for (n = 1; n < 300 && !step_down_clk_tick; n++) @(negedge clk);
        check(8'(n), 8'(BBM_FSW_DIV));
        step_up_enable = 1'b1;
        supply_below_threshold = 1'b1;
        wt(10);
        c1(step_up_on, 1'b1);
        c1(step_up_active_flag, 1'b1);
        // let the step-up ramp one step so a reduction can be seen
        n = 0;
        while (n < 2000 && step_up_duty == BBM_DUTY_MIN) begin
            wt(1);
            n++;
        end
        c1(step_down_duty > BBM_DUTY_MIN, 1'b1);
        step_down_at_target = 1'b1;
        d0 = step_up_duty;
        d1 = step_down_duty;
        step_up_overcurrent = 1'b1;
        wt(230);
        check(step_up_duty, d0 - BBM_DUTY_STEP);
        wt(470);
        check(step_up_duty, BBM_DUTY_MIN);
        check(step_down_duty, d1);
        step_up_overcurrent = 1'b0;
        auto_upshift_enable = 1'b1;
        mode_q.push_back(3'h1);
        host_u.send(3'h1);
        wt(2);
        c1(step_down_pwm, 1'b1);
        wt(10);
        c1(step_down_pwm, 1'b0);
        c1(step_up_pwm, 1'b1);
        load_over_threshold = 1'b1;
        for (n = 0; n < 40 && !upshift_event; n++) @(negedge clk);
        c1(upshift_event, 1'b1);
        wt(1);
        c1(auto_upshift_flag, 1'b1);
        c1(step_down_pwm, 1'b1);
        check(wake_status_one, 8'h01);
        load_over_threshold = 1'b0;
        wt(5);
        host_u.send(3'h1);
        wt(1);
        c1(step_down_pwm, 1'b1);
        wt(12);
        c1(step_down_pwm, 1'b0);
        c1(auto_upshift_flag, 1'b1);
        upshift_flag_clear = 1'b1;
        wt(1);
        upshift_flag_clear = 1'b0;
        wt(1);
        c1(auto_upshift_flag, 1'b0);
        auto_upshift_enable = 1'b0;
        settle_delay_select = 1'b1;
        host_u.send(3'h1);
        wt(12);
        c1(step_down_pwm, 1'b1);
        wt(20);
        c1(step_down_pwm, 1'b0);
        load_over_threshold = 1'b1;
        wt(30);
        c1(step_down_pwm, 1'b0);
        c1(auto_upshift_flag, 1'b0);
        load_over_threshold = 1'b0;
        pin_modulation_select = 1'b1;
        wake_input_pin = 1'b1;
        wt(8);
        c1(step_down_pwm, 1'b1);
        wake_input_pin = 1'b0;
        wt(40);
        c1(step_down_pwm, 1'b0);
        pin_modulation_select = 1'b0;
        wake_input_pin = 1'b1;
        wt(40);
        c1(step_down_pwm, 1'b0);
        wake_input_pin = 1'b0;
        repeat (8) begin
            fault_inputs = 3'($random(seed));
            wt(2);
            check({5'h0, converter_fault_status}, {5'h0, fault_inputs});
        end
        fault_inputs = 3'h0;
        host_u.send(3'h4);
        mode_q.push_back(3'h0);
        host_u.send(3'h0);
        wt(2);
        c1(step_down_pwm, 1'b1);
        c1(step_up_on, 1'b1);
        mode_q.push_back(3'h2);
        host_u.send(3'h2);
        wt(2);
        c1(step_down_on, 1'b0);
        c1(step_up_on, 1'b0);
        step_down_above_reset = 1'b0;
        mode_q.push_back(3'h4);
        transceiver_wake = 1'b1;
        wt(1);
        transceiver_wake = 1'b0;
        wt(8);
        c1(step_down_on, 1'b1);
        c1(step_up_on, 1'b1);
        c1(reset_output_pin_low_n, 1'b0);
        mode_q.push_back(3'h0);
        step_down_above_reset = 1'b1;
        wt(4);
        c1(reset_output_pin_low_n, 1'b1);
        mode_q.push_back(3'h3);
        host_u.send(3'h3);
        wt(2);
        c1(step_down_on, 1'b0);
        supply_below_threshold = 1'b0;
        supply_above_hysteresis = 1'b1;
        mode_q.push_back(3'h4);
        mode_q.push_back(3'h0);
        wake_input_pin = 1'b1;
        wt(12);
        wake_input_pin = 1'b0;
        c1(step_up_on, 1'b0);
        c1(step_up_active_flag, 1'b1);
        step_up_flag_clear = 1'b1;
        wt(1);
        step_up_flag_clear = 1'b0;
        c1(step_up_active_flag, 1'b0);
        c1(mode_q.size() == 0, 1'b1);
        results();
    end
endmodule
`default_nettype wire
